//--- hdl/core_space_defs.svh
`ifndef CORE_SPACE_DEFS_SVH
`define CORE_SPACE_DEFS_SVH

// data-space addresses
`define ADDR_POINTER_ONE 8'h80
`define ADDR_POINTER_TWO 8'h81
`define ADDR_SHORT_ONE 8'h82
`define ADDR_SHORT_TWO 8'h83
`define ADDR_WINDOW_PAGE 8'hc9
`define ADDR_ACCUMULATOR 8'hff
`define WINDOW_LO 8'h40
`define WINDOW_HI 8'h7f

// program-space vectors and user areas
`define VEC_RESET_LO 12'hffe
`define VEC_RESET_HI 12'hfff
`define VEC_NMI_LO 12'hffc
`define VEC_NMI_HI 12'hffd
`define VEC_IRQ_LO 12'hff0
`define VEC_IRQ_HI 12'hff7
`define USER_SMALL_LO 12'hba0
`define USER_LARGE_LO 12'h880
`define USER_HI 12'hf9f

// low option byte fields
`define OPT_PROTECT 7
`define OPT_OSC_TYPE 6
`define OPT_LO_ZERO 5
`define OPT_LO_ONE_A 4
`define OPT_NMI_PULL 3
`define OPT_LO_ONE_B 2
`define OPT_DOG_HW 1
`define OPT_GUARD_EN 0
// high option byte fields (bit numbers within the high byte)
`define OPT_STOP_OVR 1
`define OPT_LOW_SUPPLY 0
`define OPT_HI_ONE 2
`define OPT_HI_ZERO_MASK 8'hf8

// fixed values
`define WINDOW_BITS 6
`define PC_RESET 12'h000

`endif

//--- hdl/core_space_pkg.sv
package core_space_pkg;

    // data-space access from the cpu core
    typedef struct packed {
        logic rd;
        logic wr;
        logic bitOp;
        logic [7:0] addr;
        logic [7:0] wdata;
    } data_req_t;

    // decoded option settings
    typedef struct packed {
        logic readoutLock;
        logic oscTypeSelect;
        logic nmiPullUp;
        logic dogHwActivation;
        logic oscGuardEn;
        logic stopPinOverride;
        logic lowSupplyResetEn;
    } option_cfg_t;

    // program-counter control from the sequencer
    typedef enum logic [2:0] {
        PC_HOLD,
        PC_INC,
        PC_LOAD,
        PC_RESET_VEC,
        PC_NMI_VEC,
        PC_IRQ_VEC
    } pc_op_t;

    typedef enum {
        OPT_IDLE,
        OPT_LOAD,
        OPT_RUN
    } opt_state_t;

endpackage

//--- hdl/option_loader.sv
`timescale 1ns/1ns
`include "core_space_defs.svh"

// latches both option bytes once after each reset release
module option_loader (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic [15:0] optionWord, // option storage output
    input wire logic programMode, // programming mode
    output core_space_pkg::option_cfg_t cfg, // decoded options
    output logic loaded // options applied
);
    typedef struct packed {
        core_space_pkg::opt_state_t st;
        logic [15:0] word;
    } ldr_state_t;

    ldr_state_t s_reg;
    ldr_state_t s_next;

    // capture at release, not under reset, so no port reaches an async load
    always_comb
    begin
        s_next = s_reg;
        unique case (s_reg.st)
            core_space_pkg::OPT_IDLE: s_next.st = core_space_pkg::OPT_LOAD;
            core_space_pkg::OPT_LOAD:
            begin
                s_next.word = optionWord;
                s_next.st = core_space_pkg::OPT_RUN;
            end
            core_space_pkg::OPT_RUN:
            begin
                // programmer writes are not seen until the next reset
                if (programMode)
                    s_next.word = s_reg.word;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_reg <= '{st: core_space_pkg::OPT_IDLE, word: 16'h0000};
        else
            s_reg <= s_next;
    end

    assign loaded = (s_reg.st == core_space_pkg::OPT_RUN);
    // reserved bits are ignored, only named fields decode
    assign cfg.readoutLock = s_reg.word[`OPT_PROTECT];
    assign cfg.oscTypeSelect = s_reg.word[`OPT_OSC_TYPE];
    assign cfg.nmiPullUp = s_reg.word[`OPT_NMI_PULL];
    assign cfg.dogHwActivation = s_reg.word[`OPT_DOG_HW];
    assign cfg.oscGuardEn = s_reg.word[`OPT_GUARD_EN];
    assign cfg.stopPinOverride = s_reg.word[8 + `OPT_STOP_OVR];
    assign cfg.lowSupplyResetEn = s_reg.word[8 + `OPT_LOW_SUPPLY];
endmodule

//--- hdl/core_data_space.sv
`timescale 1ns/1ns
`include "core_space_defs.svh"

module core_data_space (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input core_space_pkg::data_req_t dreq, // core data-space access
    output logic [7:0] rdata, // read data
    output logic hit, // address is owned here
    output logic [11:0] progAddr, // program memory address
    input wire logic [7:0] progData, // program memory byte
    input wire logic [1:0] sqDone, // unused upper sequencer tag
    input core_space_pkg::pc_op_t pcOp, // pc operation
    input wire logic [11:0] pcLoad, // pc load value
    output logic [11:0] pc, // program counter
    input wire logic largeVariant, // larger memory variant strap
    output logic userRange, // pc inside user area
    input wire logic [15:0] optionWord, // option storage
    input wire logic programMode, // programming mode
    input wire logic extRead, // programmer read request
    input wire logic [11:0] extAddr, // programmer read address
    output logic [7:0] extData, // programmer read data
    input wire logic nmiPin, // nmi pin level
    input wire logic dogActive, // watchdog running
    input wire logic stopReq, // stop instruction executing
    output logic stopAllowed, // stop may be entered
    input wire logic lowSupply, // supply below threshold
    output logic lowSupplyReset, // reset request from supply
    output core_space_pkg::option_cfg_t cfg, // applied options
    output logic windowWriteBlocked // bit op hit the window page
);
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] ptrOne;
        logic [7:0] ptrTwo;
        logic [7:0] shortOne;
        logic [7:0] shortTwo;
        logic [11:0] pc;
        logic [7:0] rdata;
        logic [7:0] extData;
        logic [1:0] nmiSync;
        logic [1:0] supplySync;
        logic [1:0] strapSync;
        logic variant;
        logic loadedSeen;
        logic bitOpSeen;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic [`WINDOW_BITS-1:0] windowPage_reg; // no reset on purpose
    logic optLoaded;

    option_loader option_loader_i (
        .clk(clk),
        .rst(rst),
        .optionWord(optionWord),
        .programMode(programMode),
        .cfg(cfg),
        .loaded(optLoaded)
    );

    function automatic logic inWindow(input logic [7:0] a);
        inWindow = (a >= `WINDOW_LO) && (a <= `WINDOW_HI);
    endfunction

    function automatic logic ownsAddr(input logic [7:0] a);
        ownsAddr = inWindow(a) || a == `ADDR_ACCUMULATOR || a == `ADDR_POINTER_ONE
            || a == `ADDR_POINTER_TWO || a == `ADDR_SHORT_ONE || a == `ADDR_SHORT_TWO
            || a == `ADDR_WINDOW_PAGE;
    endfunction

    // window page sits outside the reset struct so reset leaves it alone
    always_ff @(posedge clk)
    begin
        if (dreq.wr && !dreq.bitOp && dreq.addr == `ADDR_WINDOW_PAGE)
            windowPage_reg <= dreq.wdata[`WINDOW_BITS-1:0];
    end

    // program memory port shared by window reads and programmer readout
    always_comb
    begin
        if (dreq.rd && inWindow(dreq.addr))
            progAddr = {windowPage_reg, dreq.addr[5:0]};
        else if (extRead)
            progAddr = extAddr;
        else
            progAddr = s_reg.pc;
    end

    // data-space registers, pc and synchronisers
    always_comb
    begin
        s_next = s_reg;
        s_next.nmiSync = {s_reg.nmiSync[0], nmiPin};
        s_next.supplySync = {s_reg.supplySync[0], lowSupply};
        s_next.strapSync = {s_reg.strapSync[0], largeVariant};
        s_next.bitOpSeen = 1'b0;
        s_next.loadedSeen = optLoaded;
        // strap needs two edges to clear the synchroniser; keep sampling one edge past load
        if (!s_reg.loadedSeen)
            s_next.variant = s_reg.strapSync[1];
        // plain data locations, any mode may write
        if (dreq.wr)
        begin
            unique case (dreq.addr)
                `ADDR_ACCUMULATOR: s_next.acc = dreq.wdata;
                `ADDR_POINTER_ONE: s_next.ptrOne = dreq.wdata;
                `ADDR_POINTER_TWO: s_next.ptrTwo = dreq.wdata;
                `ADDR_SHORT_ONE: s_next.shortOne = dreq.wdata;
                `ADDR_SHORT_TWO: s_next.shortTwo = dreq.wdata;
                default: s_next.acc = s_reg.acc;
            endcase
            if (dreq.bitOp && dreq.addr == `ADDR_WINDOW_PAGE)
                s_next.bitOpSeen = 1'b1; // ignored, flagged only
        end
        // read data; write-only page reads as zero
        if (dreq.rd)
        begin
            unique case (dreq.addr)
                `ADDR_ACCUMULATOR: s_next.rdata = s_reg.acc;
                `ADDR_POINTER_ONE: s_next.rdata = s_reg.ptrOne;
                `ADDR_POINTER_TWO: s_next.rdata = s_reg.ptrTwo;
                `ADDR_SHORT_ONE: s_next.rdata = s_reg.shortOne;
                `ADDR_SHORT_TWO: s_next.rdata = s_reg.shortTwo;
                default: s_next.rdata = inWindow(dreq.addr) ? progData : 8'h00;
            endcase
        end
        // readout lock returns zero to the programmer
        if (extRead && !(dreq.rd && inWindow(dreq.addr)))
            s_next.extData = cfg.readoutLock ? 8'h00 : progData;
        // 12-bit pc wraps naturally over 4096 bytes
        unique case (pcOp)
            core_space_pkg::PC_HOLD: s_next.pc = s_reg.pc;
            core_space_pkg::PC_INC: s_next.pc = s_reg.pc + 12'h001;
            core_space_pkg::PC_LOAD: s_next.pc = pcLoad;
            core_space_pkg::PC_RESET_VEC: s_next.pc = `VEC_RESET_LO;
            core_space_pkg::PC_NMI_VEC: s_next.pc = `VEC_NMI_LO;
            core_space_pkg::PC_IRQ_VEC: s_next.pc = `VEC_IRQ_LO;
            default: s_next.pc = s_reg.pc;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_reg <= '{acc: 8'h00, ptrOne: 8'h00, ptrTwo: 8'h00, shortOne: 8'h00,
                shortTwo: 8'h00, pc: `PC_RESET, rdata: 8'h00, extData: 8'h00,
                nmiSync: 2'h0, supplySync: 2'h0, strapSync: 2'h0, variant: 1'b0,
                loadedSeen: 1'b0, bitOpSeen: 1'b0};
        else
            s_reg <= s_next;
    end

    assign rdata = s_reg.rdata;
    assign extData = s_reg.extData;
    assign pc = s_reg.pc;
    assign hit = ownsAddr(dreq.addr);
    assign windowWriteBlocked = s_reg.bitOpSeen;

    // user area depends on the strapped variant
    assign userRange = (s_reg.pc <= `USER_HI) &&
        (s_reg.pc >= (s_reg.variant ? `USER_LARGE_LO : `USER_SMALL_LO));

    // stop gating: watchdog idle, or override with nmi held high
    assign stopAllowed = stopReq && optLoaded && (!dogActive ||
        (cfg.stopPinOverride && s_reg.nmiSync[1]));

    // supply monitor only resets when enabled
    assign lowSupplyReset = optLoaded && cfg.lowSupplyResetEn && s_reg.supplySync[1];
    // reach the clock, pad and watchdog blocks through cfg
endmodule

//--- tb/far_side_model.sv
`timescale 1ns/1ns

// program memory and option storage as the programmer leaves them
module far_side_model (
    input wire logic [15:0] optSel, // wanted option values
    input wire logic [11:0] progAddr, // program memory address
    output logic [7:0] progData, // program memory byte
    output logic [15:0] optionWord // option storage
);
    // reserved option bits always written as the programmer must
    assign optionWord = (optSel & 16'h03cb) | 16'h0414;
    // pattern mixes page and offset so a wrong page shows up
    assign progData = progAddr[7:0] ^ {progAddr[11:8], 4'h5};
endmodule

//--- tb/core_data_space_monitor.sv
`timescale 1ns/1ns

module core_data_space_monitor (
    input wire logic clk, // core clock
    input wire logic rst, // async reset
    input core_space_pkg::data_req_t dreq, // data access
    input wire logic [7:0] rdata, // read data
    input wire logic [11:0] progAddr, // program address
    input wire logic [7:0] progData, // program byte
    input core_space_pkg::pc_op_t pcOp, // pc operation
    input wire logic [11:0] pc, // program counter
    input wire logic [7:0] extData, // programmer data
    input core_space_pkg::option_cfg_t cfg, // options
    input wire logic dogActive, // watchdog running
    input wire logic stopAllowed, // stop permitted
    input wire logic lowSupplyReset, // supply reset
    input wire logic windowWriteBlocked // refused bit op
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_acc;
        dreq.wr && !dreq.bitOp && dreq.addr == 8'hff ##1 dreq.rd && dreq.addr == 8'hff
            |=> rdata == $past(dreq.wdata, 2);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator readback");
    property p_wpread;
        dreq.rd && dreq.addr == 8'hc9 |=> rdata == 8'h00;
    endproperty
    a_wpread: assert property (p_wpread) else $error("page read not zero");
    property p_wpbit;
        dreq.wr && dreq.bitOp && dreq.addr == 8'hc9 |-> ##[0:1] windowWriteBlocked;
    endproperty
    a_wpbit: assert property (p_wpbit) else $error("bit op not refused");
    property p_winaddr;
        dreq.rd && dreq.addr[7:6] == 2'b01 |-> progAddr[5:0] == dreq.addr[5:0];
    endproperty
    a_winaddr: assert property (p_winaddr) else $error("window address");
    property p_windata;
        dreq.rd && dreq.addr[7:6] == 2'b01 |=> rdata == $past(progData);
    endproperty
    a_windata: assert property (p_windata) else $error("window data");
    property p_lock;
        cfg.readoutLock && $past(cfg.readoutLock) |-> extData == 8'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("locked readout leaked");
    property p_stop;
        dogActive && !cfg.stopPinOverride |-> !stopAllowed;
    endproperty
    a_stop: assert property (p_stop) else $error("stop with watchdog");
    property p_lvr;
        !cfg.lowSupplyResetEn |-> !lowSupplyReset;
    endproperty
    a_lvr: assert property (p_lvr) else $error("supply reset disabled");
    property p_vec;
        pcOp == core_space_pkg::PC_NMI_VEC |=> pc == 12'hffc;
    endproperty
    a_vec: assert property (p_vec) else $error("nmi vector");
    property p_inc;
        pcOp == core_space_pkg::PC_INC |=> pc == $past(pc) + 12'h001;
    endproperty
    a_inc: assert property (p_inc) else $error("pc step");
endmodule

bind core_data_space core_data_space_monitor core_data_space_monitor_i (.clk, .rst, .dreq,
    .rdata, .progAddr, .progData, .pcOp, .pc, .extData, .cfg, .dogActive, .stopAllowed,
    .lowSupplyReset, .windowWriteBlocked);

//--- tb/core_data_space_tb.sv
`timescale 1ns/1ns

module core_data_space_tb;
    logic clk = 0, rst = 1, lv = 0, extRead = 0, nmiPin = 0, dogActive = 0, stopReq = 0;
    logic lowSupply = 0, userRange, stopAllowed, lowSupplyReset, wb, hit;
    logic [7:0] rdata, progData, extData;
    logic [11:0] progAddr, pc, pcLoad = 0, extAddr = 0;
    logic [15:0] optSel = 0, optionWord;
    core_space_pkg::data_req_t dreq = '0;
    core_space_pkg::pc_op_t pcOp = core_space_pkg::PC_HOLD;
    core_space_pkg::option_cfg_t cfg;
    int err_count = 0, compares = 0;
    logic [7:0] regs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};

    core_data_space core_data_space_i (.clk, .rst, .dreq, .rdata, .hit, .progAddr,
        .progData, .sqDone(2'h0), .pcOp, .pcLoad, .pc, .largeVariant(lv), .userRange,
        .optionWord, .programMode(1'b0), .extRead, .extAddr, .extData, .nmiPin, .dogActive,
        .stopReq, .stopAllowed, .lowSupply, .lowSupplyReset, .cfg, .windowWriteBlocked(wb));
    far_side_model far_side_model_i (.optSel, .progAddr, .progData, .optionWord);

    // clock and hang guard
    initial forever #5 clk = ~clk;
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end

    function automatic logic [7:0] mem(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reset held five cycles, then room for the option load
    task automatic restart(input logic [15:0] o, input logic v);
        rst = 1;
        optSel = o;
        lv = v;
        repeat (5) cyc();
        rst = 0;
        repeat (4) cyc();
    endtask
    // request stands until the next call replaces it, so back-to-back calls never
    // assign the same signal twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
        dreq = {2'b01, b, a, d};
        cyc();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        dreq = {3'b100, a, 8'h00};
        cyc();
        check(rdata, e);
    endtask
    task automatic pcdo(input core_space_pkg::pc_op_t op, input logic [11:0] v);
        pcOp = op;
        pcLoad = v;
        cyc();
    endtask
    task automatic ext(input logic [7:0] e);
        extAddr = 12'h123;
        extRead = 1;
        cyc();
        extRead = 0;
        check(extData, e);
    endtask

    // all options set, then all clear, with option-driven behaviour each time
    initial
    begin
        restart(16'hffff, 1'b1);
        check(cfg, 12'h07f);
        pcdo(core_space_pkg::PC_LOAD, 12'h880);
        check(userRange, 12'h001);
        ext(8'h00);
        dogActive = 1;
        stopReq = 1;
        nmiPin = 1;
        lowSupply = 1;
        repeat (3) cyc();
        check(stopAllowed, 12'h001);
        check(lowSupplyReset, 12'h001);
        lowSupply = 0;
        nmiPin = 0;
        repeat (3) cyc();
        check(stopAllowed, 12'h000);
        restart(16'h0000, 1'b0);
        check(cfg, 12'h000);
        check(stopAllowed, 12'h000);
        lowSupply = 1;
        repeat (3) cyc();
        check(lowSupplyReset, 12'h000);
        lowSupply = 0;
        ext(mem(12'h123));
        pcdo(core_space_pkg::PC_LOAD, 12'h880);
        check(userRange, 12'h000);
        pcdo(core_space_pkg::PC_LOAD, 12'hba0);
        check(userRange, 12'h001);
        pcdo(core_space_pkg::PC_RESET_VEC, 12'h000);
        check(pc, 12'hffe);
        pcdo(core_space_pkg::PC_NMI_VEC, 12'h000);
        check(pc, 12'hffc);
        pcdo(core_space_pkg::PC_IRQ_VEC, 12'h000);
        check(pc, 12'hff0);
        pcdo(core_space_pkg::PC_LOAD, 12'hfff);
        pcdo(core_space_pkg::PC_INC, 12'h000);
        check(pc, 12'h000);
        pcOp = core_space_pkg::PC_HOLD;
        // back-to-back write and read of each core register
        foreach (regs[i])
        begin
            wr(regs[i], regs[i] ^ 8'h5a, 1'b0);
            rd(regs[i], regs[i] ^ 8'h5a);
        end
        // top page bits ignored, page feeds upper address bits
        wr(8'hc9, 8'hc5, 1'b0);
        rd(8'h40, mem(12'h140));
        rd(8'h7f, mem(12'h17f));
        rd(8'hc9, 8'h00);
        wr(8'hc9, 8'h0a, 1'b1);
        check(wb, 12'h001);
        check(hit, 12'h001);
        rd(8'h40, mem(12'h140));
        check(wb, 12'h000);
        check(hit, 12'h001);
        rd(8'h10, 8'h00);
        check(hit, 12'h000);
        give_verdict();
    end
endmodule
